/* hw/iovf_fault_response.sv */
// input over-voltage fault response: threshold and action registers,
// fault detection, delay, retry and latch-off of the converter output
// assumes a management front end that hands over decoded commands, a
// measured input voltage in linear format with the threshold's exponent,
// and the time-unit length from the separate time-unit register
//
// Summary of operation
// RQ1: sixteen-bit linear-format trip threshold, read and written by word commands
// RQ2: eight-bit action setting by byte commands; bits 7:6 pick the fault action
// RQ3: action 00 ignores the fault; the output keeps running
// RQ4: action 01 keeps running for delay count times the time unit
// RQ5: if over-voltage persists when that delay ends, apply the retry setting
// RQ6: action 10 disables the output at once, then applies the retry setting
// RQ7: action 11 disables the output until the fault is cleared
// RQ8: status clear, clear-faults, reset or an off-on cycle clears a latched fault
// RQ9: retry setting 000 makes no restart; output stays off until cleared
// RQ10: retry 1 to 6 restarts that many times, then latches off
// RQ11: restart attempts start one delay (count times unit) apart
// RQ12: retry 111 retries forever until commanded off or another fault shuts down
// RQ13: delay code n means 2 to the n time units, 1 to 128
// RQ14: time-unit length comes from the separate time-unit register, not here
// RQ15: fault declared when measured input voltage exceeds the threshold
`timescale 1ns/100ps
module iovf_fault_response import iovf_pkg::*; #(
    parameter int UNIT_W = IOVF_UNIT_W
) (
    input wire logic clk_in, // 50 MHz clock
    input wire logic rst_n_in, // synchronous reset, active low
    input wire logic cmd_valid_in, // pulse: decoded command present
    input wire logic cmd_write_in, // 1 write, 0 read
    input wire logic [7:0] cmd_code_in, // command code
    input wire logic [15:0] cmd_wdata_in, // write data, byte in low bits
    output logic [15:0] cmd_rdata_out, // read data
    output logic cmd_ack_out, // pulse: command accepted
    output logic cmd_nack_out, // pulse: command code not served here
    input wire logic [15:0] vin_meas_in, // measured input voltage, linear
    input wire logic [UNIT_W-1:0] unit_cycles_in, // clocks per delay unit
    input wire logic status_clear_in, // pulse: clear the status bit
    input wire logic clear_faults_in, // pulse: clear-faults command
    input wire logic ctrl_pin_in, // remote on/off pin, asynchronous
    input wire logic operation_on_in, // operation command says on
    input wire logic other_fault_in, // another fault shut the unit down
    output logic output_enable_out, // converter output enabled
    output logic fault_status_out, // sticky over-voltage status bit
    output logic restart_out, // pulse: restart attempt made
    output logic [2:0] attempts_out // failed restart attempts so far under retry 1 to 6
);

    // ------------------------------------------------------------
    // registers and command port
    // ------------------------------------------------------------
    logic [15:0] threshold_ff;
    logic [7:0] action_ff;
    logic [15:0] rdata_ff;
    logic ack_ff;
    logic nack_ff;

    // word and byte commands; other codes belong to other blocks
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            threshold_ff <= IOVF_THRESHOLD_RST;
            action_ff <= IOVF_ACTION_RST;
            rdata_ff <= '0;
            ack_ff <= 1'b0;
            nack_ff <= 1'b0;
        end else begin
            ack_ff <= 1'b0;
            nack_ff <= 1'b0;
            if (cmd_valid_in) begin
                if (cmd_code_in == IOVF_CMD_THRESHOLD) begin
                    ack_ff <= 1'b1;
                    if (cmd_write_in) begin
                        threshold_ff <= cmd_wdata_in; // RQ1
                    end else begin
                        rdata_ff <= threshold_ff; // RQ1
                    end
                end else if (cmd_code_in == IOVF_CMD_ACTION) begin
                    ack_ff <= 1'b1;
                    if (cmd_write_in) begin
                        action_ff <= cmd_wdata_in[7:0]; // RQ2
                    end else begin
                        rdata_ff <= {8'h00, action_ff}; // RQ2
                    end
                end else begin
                    nack_ff <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // on/off command and its synchroniser
    // ------------------------------------------------------------
    logic ctrl_s1_ff;
    logic ctrl_s2_ff;
    logic ctrl_s3_ff;
    logic ctrl_ff;
    logic on_prev_ff;
    logic on_cmd;
    logic on_rise;

    // three stages; the pin level moves only when stages two and three agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_s1_ff <= 1'b0;
            ctrl_s2_ff <= 1'b0;
            ctrl_s3_ff <= 1'b0;
            ctrl_ff <= 1'b0;
        end else begin
            ctrl_s1_ff <= ctrl_pin_in;
            ctrl_s2_ff <= ctrl_s1_ff;
            ctrl_s3_ff <= ctrl_s2_ff;
            if (ctrl_s2_ff == ctrl_s3_ff) begin
                ctrl_ff <= ctrl_s3_ff;
            end
        end
    end

    assign on_cmd = ctrl_ff && operation_on_in;

    // previous on state, for the off-then-on clearing edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            on_prev_ff <= 1'b0;
        end else begin
            on_prev_ff <= on_cmd;
        end
    end

    assign on_rise = on_cmd && !on_prev_ff;

    // ------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------
    // signed mantissa compare; exponents are taken as equal, which
    // saves a normaliser but leaves scaling to the measurement path
    function automatic logic over_limit(input logic [15:0] meas, input logic [15:0] lim);
        over_limit = $signed(meas[IOVF_MANT_MSB:0]) > $signed(lim[IOVF_MANT_MSB:0]);
    endfunction

    logic over_trip;
    logic any_clear;
    logic [1:0] act;
    logic [2:0] retry_set;

    assign over_trip = over_limit(vin_meas_in, threshold_ff); // RQ15
    assign any_clear = status_clear_in || clear_faults_in || on_rise; // RQ8
    assign act = action_ff[IOVF_ACT_MSB:IOVF_ACT_LSB];
    assign retry_set = action_ff[IOVF_RETRY_MSB:IOVF_RETRY_LSB];

    // ------------------------------------------------------------
    // response state machine
    // ------------------------------------------------------------
    iovf_state_t state_ff;
    iovf_state_t nxt_state;
    logic [2:0] attempts_ff;
    logic [2:0] nxt_attempts;
    logic timer_start;
    logic timer_done;
    logic fault_event;
    logic restart_pulse;

    always_comb begin
        nxt_state = state_ff;
        nxt_attempts = attempts_ff;
        timer_start = 1'b0;
        fault_event = 1'b0;
        restart_pulse = 1'b0;
        case (state_ff)
            IOVF_ST_RUN: begin
                if (over_trip) begin
                    fault_event = 1'b1; // RQ15
                    nxt_attempts = 3'h0;
                    if (act == IOVF_ACT_DELAYED) begin
                        nxt_state = IOVF_ST_GRACE; // RQ4
                        timer_start = 1'b1;
                    end else if (act == IOVF_ACT_RETRY) begin
                        if (retry_set == IOVF_RETRY_NONE) begin
                            nxt_state = IOVF_ST_LATCHED; // RQ9
                        end else begin
                            nxt_state = IOVF_ST_RETRY_WAIT; // RQ6
                            timer_start = 1'b1;
                        end
                    end else if (act == IOVF_ACT_LATCH) begin
                        nxt_state = IOVF_ST_LATCHED; // RQ7
                    end
                    // ignore action leaves the output running; RQ3
                end
            end
            IOVF_ST_GRACE: begin
                if (timer_done) begin
                    if (!over_trip) begin
                        nxt_state = IOVF_ST_RUN;
                    end else if (retry_set == IOVF_RETRY_NONE) begin
                        nxt_state = IOVF_ST_LATCHED; // RQ5
                    end else begin
                        nxt_state = IOVF_ST_RETRY_WAIT; // RQ5
                        timer_start = 1'b1;
                    end
                end
            end
            IOVF_ST_RETRY_WAIT: begin
                if (timer_done) begin
                    restart_pulse = 1'b1;
                    if (!over_trip) begin
                        nxt_state = IOVF_ST_RUN;
                    end else if (retry_set != IOVF_RETRY_ENDLESS &&
                                 attempts_ff + 3'h1 >= retry_set) begin
                        nxt_attempts = attempts_ff + 3'h1;
                        nxt_state = IOVF_ST_LATCHED; // RQ10
                    end else begin
                        // the endless setting never counts up; RQ12
                        if (retry_set != IOVF_RETRY_ENDLESS) begin
                            nxt_attempts = attempts_ff + 3'h1;
                        end
                        timer_start = 1'b1; // RQ11
                    end
                end
            end
            IOVF_ST_LATCHED: begin
                if (any_clear) begin
                    nxt_state = IOVF_ST_RUN; // RQ8
                end
            end
            IOVF_ST_CMD_OFF: begin
                if (on_rise && !other_fault_in) begin
                    nxt_state = IOVF_ST_RUN; // RQ8
                end
            end
            default: begin
                nxt_state = IOVF_ST_RUN;
            end
        endcase
        // being commanded off or shut by another fault overrides all; RQ12
        if (!on_cmd || other_fault_in) begin
            nxt_state = IOVF_ST_CMD_OFF;
            timer_start = 1'b0;
            restart_pulse = 1'b0;
            fault_event = 1'b0;
        end
    end

    // state and attempt count
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= IOVF_ST_CMD_OFF;
            attempts_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            attempts_ff <= nxt_attempts;
        end
    end

    // unit length from the time-unit input, delay code from the action byte
    iovf_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(timer_start),
        .code_in(action_ff[IOVF_DELAY_MSB:IOVF_DELAY_LSB]),
        .unit_cycles_in(unit_cycles_in), // RQ14
        .busy_out(),
        .done_out(timer_done)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic enable_ff;
    logic status_ff;
    logic restart_ff;

    // a new fault in the clearing cycle wins so no event is lost
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            enable_ff <= 1'b0;
            status_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            enable_ff <= (nxt_state == IOVF_ST_RUN) || (nxt_state == IOVF_ST_GRACE);
            restart_ff <= restart_pulse;
            if (fault_event) begin
                status_ff <= 1'b1;
            end else if (any_clear) begin
                status_ff <= 1'b0; // RQ8
            end
        end
    end

    assign cmd_rdata_out = rdata_ff;
    assign cmd_ack_out = ack_ff;
    assign cmd_nack_out = nack_ff;
    assign output_enable_out = enable_ff;
    assign fault_status_out = status_ff;
    assign restart_out = restart_ff;
    assign attempts_out = attempts_ff;

endmodule

/* common/iovf_pkg.sv */
// input over-voltage fault response: shared constants and types
// assumes the management interface has already decoded the bus protocol
// into command code, direction and data before it reaches this block
package iovf_pkg;

    // ------------------------------------------------------------
    // command codes and layout
    // ------------------------------------------------------------
    localparam logic [7:0] IOVF_CMD_THRESHOLD = 8'h55;
    localparam logic [7:0] IOVF_CMD_ACTION = 8'h56;
    localparam int IOVF_ACT_MSB = 7;
    localparam int IOVF_ACT_LSB = 6;
    localparam int IOVF_RETRY_MSB = 5;
    localparam int IOVF_RETRY_LSB = 3;
    localparam int IOVF_DELAY_MSB = 2;
    localparam int IOVF_DELAY_LSB = 0;
    localparam int IOVF_MANT_MSB = 10;

    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [15:0] IOVF_THRESHOLD_RST = 16'h03ff;
    localparam logic [7:0] IOVF_ACTION_RST = 8'hc0;
    localparam logic [1:0] IOVF_ACT_IGNORE = 2'h0;
    localparam logic [1:0] IOVF_ACT_DELAYED = 2'h1;
    localparam logic [1:0] IOVF_ACT_RETRY = 2'h2;
    localparam logic [1:0] IOVF_ACT_LATCH = 2'h3;
    localparam logic [2:0] IOVF_RETRY_NONE = 3'h0;
    localparam logic [2:0] IOVF_RETRY_ENDLESS = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int IOVF_UNIT_W = 24;
    localparam int IOVF_UNITS_W = 8;

    typedef enum logic [2:0] {
        IOVF_ST_RUN,
        IOVF_ST_GRACE,
        IOVF_ST_RETRY_WAIT,
        IOVF_ST_LATCHED,
        IOVF_ST_CMD_OFF
    } iovf_state_t;

endpackage

/* hw/iovf_delay_timer.sv */
// delay timer: counts 2**code time units, one unit being unit_cycles clocks
// assumes start_in is a one-cycle pulse; a new start restarts the count
`timescale 1ns/100ps
module iovf_delay_timer import iovf_pkg::*; #(
    parameter int UNIT_W = IOVF_UNIT_W
) (
    input wire logic clk_in, // 50 MHz clock
    input wire logic rst_n_in, // synchronous reset, active low
    input wire logic start_in, // pulse: begin a new delay
    input wire logic [2:0] code_in, // delay code n, 2**n units
    input wire logic [UNIT_W-1:0] unit_cycles_in, // clocks per time unit
    output logic busy_out, // delay in progress
    output logic done_out // pulse: delay expired
);

    // ------------------------------------------------------------
    // unit divider and unit counter
    // ------------------------------------------------------------
    logic [UNIT_W-1:0] div_ff;
    logic [IOVF_UNITS_W-1:0] units_ff;
    logic busy_ff;
    logic unit_tick;

    // zero cycles per unit is treated as one so a delay always ends
    assign unit_tick = busy_ff && (div_ff <= UNIT_W'(1));

    // divider restarts with each start so the first unit is whole
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_ff <= '0;
        end else if (start_in || unit_tick) begin
            div_ff <= unit_cycles_in;
        end else if (busy_ff) begin
            div_ff <= div_ff - UNIT_W'(1);
        end
    end

    // count of units still to run
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            units_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            if (start_in) begin
                units_ff <= IOVF_UNITS_W'(1) << code_in; // RQ13
                busy_ff <= 1'b1;
            end else if (unit_tick) begin
                units_ff <= units_ff - IOVF_UNITS_W'(1);
                if (units_ff == IOVF_UNITS_W'(1)) begin
                    busy_ff <= 1'b0;
                end
            end
        end
    end

    assign busy_out = busy_ff;
    // done in the last unit's cycle, so a restart lands exactly one delay on
    assign done_out = unit_tick && (units_ff == IOVF_UNITS_W'(1));

endmodule

/* verification/iovf_fault_sva.sv */
// assertions for the over-voltage fault block, bound to its ports
// assumes the threshold and action registers change only by host writes
`timescale 1ns/100ps
module iovf_fault_sva import iovf_pkg::*; #(
    parameter int UNIT_W = IOVF_UNIT_W
) (
    input wire logic clk_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic cmd_valid_in, // command
    input wire logic cmd_write_in, // direction
    input wire logic [7:0] cmd_code_in, // code
    input wire logic [15:0] cmd_wdata_in, // write data
    input wire logic [15:0] cmd_rdata_out, // read data
    input wire logic cmd_ack_out, // ack
    input wire logic cmd_nack_out, // nack
    input wire logic [15:0] vin_meas_in, // voltage
    input wire logic [UNIT_W-1:0] unit_cycles_in, // unit
    input wire logic status_clear_in, // clear
    input wire logic clear_faults_in, // clear
    input wire logic ctrl_pin_in, // pin
    input wire logic operation_on_in, // on
    input wire logic other_fault_in, // shutdown
    input wire logic output_enable_out, // output
    input wire logic fault_status_out, // status
    input wire logic restart_out // restart
);
    // ----------------------------------------------------------
    // shadow registers and gap counter
    // ----------------------------------------------------------
    logic [7:0] act_ff;
    logic [15:0] thr_ff;
    int gap_ff;
    int dly;
    logic over;
    logic served;
    assign over = $signed(vin_meas_in[10:0]) > $signed(thr_ff[10:0]);
    assign served = cmd_code_in == IOVF_CMD_THRESHOLD || cmd_code_in == IOVF_CMD_ACTION;
    // unit 0 counts as 1, so the delay is never empty
    assign dly = ((unit_cycles_in < 2) ? 1 : int'(unit_cycles_in)) << act_ff[2:0];
    // shadow copies follow host writes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            act_ff <= IOVF_ACTION_RST;
            thr_ff <= IOVF_THRESHOLD_RST;
        end else if (cmd_valid_in && cmd_write_in) begin
            if (cmd_code_in == IOVF_CMD_ACTION) act_ff <= cmd_wdata_in[7:0];
            if (cmd_code_in == IOVF_CMD_THRESHOLD) thr_ff <= cmd_wdata_in;
        end
    end
    // cycles since the output dropped or the last restart
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) gap_ff <= 0;
        else if (restart_out || $fell(output_enable_out)) gap_ff <= 1;
        else gap_ff <= gap_ff + 1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // pin held on long enough to have crossed the synchroniser
    sequence seq_trip;
        ctrl_pin_in[*4] ##0 (over && output_enable_out && operation_on_in && !other_fault_in);
    endsequence
    AST_ACK: assert property (cmd_valid_in && served |=> cmd_ack_out && !cmd_nack_out)
        else $error("served code not acknowledged");
    AST_NACK: assert property (cmd_valid_in && !served |=> cmd_nack_out && !cmd_ack_out)
        else $error("unknown code not refused");
    AST_RD_THR: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == IOVF_CMD_THRESHOLD
        |=> cmd_rdata_out == thr_ff) else $error("threshold read wrong");
    AST_RD_ACT: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == IOVF_CMD_ACTION
        |=> cmd_rdata_out == {8'h00, act_ff}) else $error("action read wrong");
    AST_IGNORE: assert property (seq_trip ##0 act_ff[7:6] == 2'b00 |=> output_enable_out[*3])
        else $error("ignored fault dropped output");
    AST_GRACE: assert property (seq_trip ##0 act_ff[7:6] == 2'b01 && !fault_status_out
        |=> output_enable_out[*2]) else $error("delayed action dropped output early");
    AST_DISABLE: assert property (seq_trip ##0 act_ff[7:6] == 2'b10 |=> !output_enable_out)
        else $error("disable action kept output on");
    AST_LATCH: assert property (seq_trip ##0 act_ff[7:6] == 2'b11 |=> !output_enable_out[*2])
        else $error("latch action kept output on");
    AST_DETECT: assert property (seq_trip |=> fault_status_out)
        else $error("fault not flagged");
    AST_CLEAR: assert property ((status_clear_in || clear_faults_in) && !over |=> !fault_status_out)
        else $error("status not cleared");
    AST_NO_RETRY: assert property (seq_trip ##0 act_ff[7:3] == 5'b10000
        |=> (!restart_out && !output_enable_out)[*8]) else $error("restart with retry off");
    AST_GAP: assert property (restart_out && act_ff[7:6] == 2'b10 |-> gap_ff == dly)
        else $error("restart spacing wrong");
endmodule
bind iovf_fault_response iovf_fault_sva #(.UNIT_W(UNIT_W)) u_sva (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
    .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
    .cmd_ack_out(cmd_ack_out), .cmd_nack_out(cmd_nack_out), .vin_meas_in(vin_meas_in),
    .unit_cycles_in(unit_cycles_in), .status_clear_in(status_clear_in),
    .clear_faults_in(clear_faults_in), .ctrl_pin_in(ctrl_pin_in),
    .operation_on_in(operation_on_in), .other_fault_in(other_fault_in),
    .output_enable_out(output_enable_out), .fault_status_out(fault_status_out),
    .restart_out(restart_out));

/* verification/iovf_host_model.sv */
// management host model: decoded commands and fault-clear pulses
// assumes the block answers one cycle after taking a command
`timescale 1ns/100ps
module iovf_host_model (
    input wire logic clk_in, // clock
    input wire logic [15:0] rdata_in, // read data
    input wire logic ack_in, // ack
    input wire logic nack_in, // nack
    output logic cmd_valid_out = 1'b0, // command pulse
    output logic cmd_write_out = 1'b0, // direction
    output logic [7:0] cmd_code_out = 8'h00, // code
    output logic [15:0] cmd_wdata_out = 16'h0000, // write data
    output logic status_clear_out = 1'b0, // status clear
    output logic clear_faults_out = 1'b0 // clear-faults
);
    // one command; idle data is inverted so stale values never look valid
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
        output logic [15:0] rd, output logic [1:0] an);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_write_out = wr;
        cmd_code_out = code;
        cmd_wdata_out = wd;
        @(negedge clk_in);
        rd = rdata_in;
        an = {ack_in, nack_in};
        cmd_valid_out = 1'b0;
        cmd_code_out = ~code;
        cmd_wdata_out = ~wd;
    endtask
    // one-cycle clear pulse: 1 clear-faults, 0 status bit
    task automatic pulse(input logic cf);
        @(negedge clk_in);
        clear_faults_out = cf;
        status_clear_out = !cf;
        @(negedge clk_in);
        clear_faults_out = 1'b0;
        status_clear_out = 1'b0;
    endtask
endmodule

/* verification/tb.sv */
// testbench for the over-voltage fault block
// assumes the host model drives the command side and the bench the rest
`timescale 1ns/100ps
module tb;
    import iovf_pkg::*;
    localparam logic [15:0] VHI = 16'h0200;
    localparam logic [15:0] VLO = 16'h0080;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] vin = VLO;
    logic [23:0] unit = 24'h000002;
    logic ctrl = 1'b0;
    logic opon = 1'b0;
    logic other = 1'b0;
    logic valid, wrt, ack, nack, sclr, cflt, en, st, rst_pulse;
    logic [7:0] code;
    logic [15:0] wd, rdat, rd;
    logic [2:0] att;
    logic [1:0] an;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    always #10 clk_in = ~clk_in;
    iovf_host_model host (.clk_in(clk_in), .rdata_in(rdat), .ack_in(ack), .nack_in(nack),
        .cmd_valid_out(valid), .cmd_write_out(wrt), .cmd_code_out(code), .cmd_wdata_out(wd),
        .status_clear_out(sclr), .clear_faults_out(cflt));
    iovf_fault_response dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(valid),
        .cmd_write_in(wrt), .cmd_code_in(code), .cmd_wdata_in(wd), .cmd_rdata_out(rdat),
        .cmd_ack_out(ack), .cmd_nack_out(nack), .vin_meas_in(vin), .unit_cycles_in(unit),
        .status_clear_in(sclr), .clear_faults_in(cflt), .ctrl_pin_in(ctrl),
        .operation_on_in(opon), .other_fault_in(other), .output_enable_out(en),
        .fault_status_out(st), .restart_out(rst_pulse), .attempts_out(att));
    // ----------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a hang would otherwise stall the run forever
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // drop the fault, clear it and see the output come back
    task automatic recover();
        vin = VLO;
        host.pulse(1'b1);
        repeat (6) @(negedge clk_in);
        chk(en === 1'b1 && st === 1'b0, "no recovery after clear");
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        host.xfer(1'b0, IOVF_CMD_THRESHOLD, 16'h0000, rd, an);
        chk(rd === IOVF_THRESHOLD_RST && an === 2'b10, "threshold reset");
        host.xfer(1'b0, IOVF_CMD_ACTION, 16'h0000, rd, an);
        chk(rd === {8'h00, IOVF_ACTION_RST}, "action reset");
        host.xfer(1'b1, IOVF_CMD_THRESHOLD, 16'h0100, rd, an);
        host.xfer(1'b1, IOVF_CMD_ACTION, 16'hff00, rd, an);
        host.xfer(1'b1, 8'h57, 16'h1234, rd, an);
        chk(an === 2'b01, "unknown code taken");
        host.xfer(1'b0, IOVF_CMD_THRESHOLD, 16'h0000, rd, an);
        chk(rd === 16'h0100, "threshold readback");
        host.xfer(1'b0, IOVF_CMD_ACTION, 16'h0000, rd, an);
        chk(rd === 16'h0000 && an === 2'b10, "byte upper bits kept");
        $display("registers done");
    endtask
    task automatic t_ignore();
        host.xfer(1'b1, IOVF_CMD_ACTION, 16'h0007, rd, an);
        vin = VHI;
        repeat (20) @(negedge clk_in);
        chk(en === 1'b1 && st === 1'b1, "ignore action");
        vin = VLO;
        host.pulse(1'b0);
        chk(st === 1'b0, "status bit not cleared");
        $display("ignore done");
    endtask
    task automatic t_latch();
        host.xfer(1'b1, IOVF_CMD_ACTION, 16'h00c0, rd, an);
        vin = VHI;
        repeat (20) @(negedge clk_in);
        vin = VLO;
        repeat (20) @(negedge clk_in);
        chk(en === 1'b0, "latched output came back");
        recover();
        $display("latch done");
    endtask
    // grace period then latch, retry setting zero
    task automatic t_delay(input logic [2:0] c);
        unit = 24'h000003;
        host.xfer(1'b1, IOVF_CMD_ACTION, {8'h00, 5'b01000, c}, rd, an);
        vin = VHI;
        n = 0;
        while (en === 1'b1 && n < 500) begin
            @(negedge clk_in);
            n++;
        end
        chk(n == 3 * (1 << c) + 1, "grace length");
        recover();
        $display("delay code %0d done", c);
    endtask
    // fault never goes away: count restart attempts
    task automatic t_retry(input logic [2:0] r);
        unit = 24'h000002;
        host.xfer(1'b1, IOVF_CMD_ACTION, {8'h00, 2'b10, r, 3'h1}, rd, an);
        vin = VHI;
        n = 0;
        repeat (84) begin
            @(negedge clk_in);
            if (rst_pulse === 1'b1) n++;
        end
        chk(en === 1'b0, "output on during retries");
        if (r != 3'h7) begin
            chk(n == int'(r) && att === r, "retry count");
        end else begin
            chk(n > 6, "endless retry stopped");
            opon = 1'b0;
            n = 0;
            repeat (30) begin
                @(negedge clk_in);
                if (rst_pulse === 1'b1) n++;
            end
            chk(n == 0, "retry after off command");
            vin = VLO;
            opon = 1'b1;
        end
        recover();
        $display("retry %0d done", r);
    endtask
    initial begin
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_regs();
        ctrl = 1'b1;
        opon = 1'b1;
        repeat (12) @(negedge clk_in);
        chk(en === 1'b1, "output never started");
        t_ignore();
        t_latch();
        for (int c = 0; c < 8; c++) t_delay(c[2:0]);
        for (int r = 0; r < 8; r++) t_retry(r[2:0]);
        report_and_stop();
    end
endmodule
